// >>> src/cwrc_core.sv
// Functional notes
// - Sixteen 16-bit working registers, each usable as data, pointer or offset.
// - The last register is the stack pointer, moved by calls and interrupts.
// - The fifteenth register is the frame pointer during link and unlink.
// - Program counter is 24 bits wide, covering 8M program words.
// - Each fetched instruction word is 24 bits with variable-length opcode.
// - One-cycle prefetch; flow changes and window accesses take extra cycles.
// - Repeat loops add no overhead and an interrupt may break in anytime.
// - Upper data half maps to program space by the 8-bit window page.
// - One cycle holds data read, register read, data write and fetch.
// - 17x17 multiplier: signed, unsigned, mixed, 16 or 8 bit, one cycle.
// - Non-restoring divide takes 19 cycles and can pause in any cycle after the start cycle.
// - Up to 8 traps and 118 interrupt sources over seven levels.
// - All programmer's model registers are memory mapped and read; all but the PC words are written.
// - Addressing mode decides whether a register acts as data or pointer.
// - File-register instructions use only the first working register.
// - File-register operands are the encoded address and the first register.
// - Data address 0x0004 reaches the third register exactly like direct naming.
// - A data write to the pointer's own register wins over post-modify.
// - Register-direct byte writes to a working register change only its low byte.
// - Low and high bytes of each register are reachable by byte access.
// - Reset clears all registers but the stack pointer, marking them uninitialized.
// - Reset loads the stack pointer with 0x0800.
// - Bit 0 of the stack pointer is always held at zero.
// - Pointer use of an uninitialized register traps; only word writes, and link for the frame pointer, initialize.
`timescale 1ns/1ns
module cwrc_core
	import cwrc_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Instruction-side requests.
	input wire cwrc_reg_op_t reg_op,
	input wire cwrc_ptr_op_t ptr_op,
	input wire cwrc_stack_op_t stk_op,
	input wire cwrc_flow_t flow,
	// Data memory bus.
	input wire cwrc_dm_req_t dm_req,
	// Arithmetic requests.
	input wire cwrc_mul_req_t mul_req,
	input wire cwrc_div_req_t div_req,
	// Exception request check.
	input wire logic irq_req,
	input wire logic [6:0] irq_src,
	input wire logic [2:0] irq_prio,
	// Register read answers.
	output logic [15:0] rd_a,
	output logic [15:0] rd_b,
	output logic [15:0] eff_addr,
	output logic addr_trap,
	// Data memory answers and program window.
	output logic [15:0] dm_rdata,
	output logic dm_hit,
	output logic prog_rd,
	output logic [23:0] prog_addr,
	// Program flow.
	output logic [23:0] pc,
	output logic [23:0] instr_word,
	output logic stall,
	output logic rep_busy,
	// Arithmetic results.
	output logic [31:0] mul_res,
	output logic [15:0] quotient,
	output logic [15:0] remainder,
	output logic div_busy,
	output logic div_done,
	output logic irq_ok
);

	// ----------------------------------------------------------------
	// Address decode helpers.
	// ----------------------------------------------------------------
	function automatic logic cwrc_in_file_op_work_reg_win(input logic [15:0] addr);
		return addr < FILE_OP_WORK_REG_WIN_END;
	endfunction : cwrc_in_file_op_work_reg_win

	function automatic logic [3:0] cwrc_file_op_work_reg_idx(input logic [15:0] addr);
		return addr[4:1];
	endfunction : cwrc_file_op_work_reg_idx

	cwrc_state_t st, next_st;
	logic [15:0] base, step, sp, dm_word;
	logic [3:0] idx;
	logic [31:0] dvd_full, dvd_mag;
	logic dvd_neg, dsr_neg;
	logic [17:0] shifted;
	logic signed [MUL_W-1:0] mul_a, mul_b;
	logic signed [2*MUL_W-1:0] product;

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	// Computes the whole next state; later writers override earlier ones.
	always_comb begin
		next_st = st;
		base = 16'h0000;
		step = STEP_WORD;
		sp = 16'h0000;
		idx = WZ_IDX;
		dm_word = 16'h0000;
		next_st.addr_trap = 1'b0;
		next_st.dm_hit = 1'b0;
		next_st.prog_rd = 1'b0;
		next_st.div_done = 1'b0;
		// Register-direct reads; file ops read the first register.
		next_st.rd_a = reg_op.file_op ? st.file_op_work_reg[WZ_IDX]
			: st.file_op_work_reg[reg_op.rd_a_sel];
		next_st.rd_b = st.file_op_work_reg[reg_op.rd_b_sel];
		// Indirect pointer use with optional pre or post modify.
		if (ptr_op.en) begin
			base = st.file_op_work_reg[ptr_op.sel];
			// The stack pointer always steps a word.
			step = (ptr_op.byte_step && ptr_op.sel != SP_IDX) ? STEP_BYTE
				: STEP_WORD;
			next_st.addr_trap = !st.init[ptr_op.sel];
			next_st.ea = base;
			unique case (ptr_op.mode)
				CWRC_PM_NONE: begin
				end
				CWRC_PM_POST_INC: begin
					next_st.file_op_work_reg[ptr_op.sel] = base + step;
				end
				CWRC_PM_POST_DEC: begin
					next_st.file_op_work_reg[ptr_op.sel] = base - step;
				end
				CWRC_PM_PRE_INC: begin
					next_st.ea = base + step;
					next_st.file_op_work_reg[ptr_op.sel] = base + step;
				end
				CWRC_PM_PRE_DEC: begin
					next_st.ea = base - step;
					next_st.file_op_work_reg[ptr_op.sel] = base - step;
				end
				default: begin
				end
			endcase
		end
		// Automatic stack and frame pointer movement.
		sp = st.file_op_work_reg[SP_IDX];
		if (stk_op.push) begin
			next_st.ea = sp;
			next_st.file_op_work_reg[SP_IDX] = sp + STEP_WORD;
		end else if (stk_op.pop) begin
			next_st.ea = sp - STEP_WORD;
			next_st.file_op_work_reg[SP_IDX] = sp - STEP_WORD;
		end else if (stk_op.link) begin
			next_st.ea = sp;
			next_st.file_op_work_reg[FP_IDX] = sp + STEP_WORD;
			next_st.init[FP_IDX] = 1'b1;
			next_st.file_op_work_reg[SP_IDX] = sp + STEP_WORD + {1'b0, stk_op.frame_bytes};
		end else if (stk_op.unlink) begin
			next_st.ea = st.file_op_work_reg[FP_IDX] - STEP_WORD;
			next_st.file_op_work_reg[SP_IDX] = st.file_op_work_reg[FP_IDX] - STEP_WORD;
		end
		// Register-direct destination write.
		if (reg_op.wr_en) begin
			idx = reg_op.file_op ? WZ_IDX : reg_op.wr_sel;
			if (reg_op.wr_byte) begin
				next_st.file_op_work_reg[idx][7:0] = reg_op.wr_data[7:0];
			end else begin
				next_st.file_op_work_reg[idx] = reg_op.wr_data;
				next_st.init[idx] = 1'b1;
			end
		end
		// Memory-mapped access; the data write is applied last.
		if (dm_req.en) begin
			if (cwrc_in_file_op_work_reg_win(dm_req.addr)) begin
				idx = cwrc_file_op_work_reg_idx(dm_req.addr);
				next_st.dm_hit = 1'b1;
				if (dm_req.we) begin
					for (int b = 0; b < 2; b++) begin
						if (dm_req.be[b]) begin
							next_st.file_op_work_reg[idx][8*b +: 8] =
								dm_req.wdata[8*b +: 8];
						end
					end
					if (dm_req.be == 2'b11) begin
						next_st.init[idx] = 1'b1;
					end
				end else begin
					next_st.dm_rdata = st.file_op_work_reg[idx];
				end
			end else if (dm_req.addr[15] && st.core_ctl[CTL_PSV_BIT]) begin
				// Upper half goes to program space through the page.
				next_st.prog_rd = 1'b1;
				next_st.prog_addr = {1'b0, st.win_page,
					dm_req.addr[PSV_OFS_W-1:0]};
			end else begin
				unique case (dm_req.addr)
					ADDR_PC_LO: dm_word = st.pc[15:0];
					ADDR_PC_HI: dm_word = {8'h00, st.pc[23:16]};
					ADDR_TBL_PAGE: dm_word = {8'h00, st.tbl_page};
					ADDR_WIN_PAGE: dm_word = {8'h00, st.win_page};
					ADDR_LOOP_CNT: dm_word = {2'b00, st.loop_count};
					ADDR_CORE_CTL: dm_word = st.core_ctl;
					default: dm_word = 16'h0000;
				endcase
				next_st.dm_rdata = dm_req.we ? st.dm_rdata : dm_word;
				if (dm_req.we && dm_req.be[0]) begin
					unique case (dm_req.addr)
						ADDR_TBL_PAGE: next_st.tbl_page = dm_req.wdata[7:0];
						ADDR_WIN_PAGE: next_st.win_page = dm_req.wdata[7:0];
						ADDR_LOOP_CNT: next_st.loop_count =
							dm_req.wdata[REP_W-1:0];
						ADDR_CORE_CTL: next_st.core_ctl = dm_req.wdata;
						default: begin
						end
					endcase
				end
			end
		end
		next_st.file_op_work_reg[SP_IDX][0] = 1'b0;
		// Multi-cycle instructions hold fetch for one extra cycle.
		next_st.stall = flow.multi && !st.stall;
		if (flow.pc_load) begin
			next_st.pc = flow.pc_target;
		end else if (flow.fetch_adv && !next_st.stall) begin
			next_st.pc = st.pc + PC_STEP;
		end
		if (flow.fetch_adv && !next_st.stall) begin
			next_st.instr = flow.fetch_word;
		end
		// Repeat counter: no overhead, frozen while an interrupt runs.
		if (flow.rep_load) begin
			next_st.loop_count = flow.rep_count;
			next_st.rep_busy = 1'b1;
		end else if (st.rep_busy && flow.fetch_adv && !flow.irq_take) begin
			if (st.loop_count == '0) begin
				next_st.rep_busy = 1'b0;
			end else begin
				next_st.loop_count = st.loop_count - 14'h0001;
			end
		end
		// Single-cycle multiply with per-operand sign extension.
		if (mul_req.en) begin
			next_st.mul_res = product[31:0];
		end
		// Iterative divider, paused while an interrupt is taken.
		unique case (st.div_state)
			CWRC_DIV_IDLE: begin
				if (div_req.start) begin
					next_st.div_p = {2'b00, dvd_mag[31:16]};
					next_st.div_a = dvd_mag[15:0];
					next_st.div_d = dsr_neg ? 16'(-div_req.divisor)
						: div_req.divisor;
					next_st.div_qneg = dvd_neg ^ dsr_neg;
					next_st.div_rneg = dvd_neg;
					next_st.div_cnt = 5'h00;
					next_st.div_state = CWRC_DIV_STEP;
				end
			end
			CWRC_DIV_STEP: begin
				if (!flow.irq_take) begin
					next_st.div_p = st.div_p[17] ?
						shifted + {2'b00, st.div_d} : shifted - {2'b00, st.div_d};
					next_st.div_a = {st.div_a[14:0], ~next_st.div_p[17]};
					next_st.div_cnt = st.div_cnt + 5'h01;
					if (st.div_cnt == DIV_LAST_STEP) begin
						next_st.div_state = CWRC_DIV_FIX;
					end
				end
			end
			CWRC_DIV_FIX: begin
				if (!flow.irq_take) begin
					if (st.div_p[17]) begin
						next_st.div_p = st.div_p + {2'b00, st.div_d};
					end
					next_st.div_state = CWRC_DIV_SIGN;
				end
			end
			CWRC_DIV_SIGN: begin
				if (!flow.irq_take) begin
					next_st.quot = st.div_qneg ? 16'(-st.div_a) : st.div_a;
					next_st.rem = st.div_rneg ? 16'(-st.div_p[15:0])
						: st.div_p[15:0];
					next_st.div_done = 1'b1;
					next_st.div_state = CWRC_DIV_IDLE;
				end
			end
		endcase
		// Accept only legal sources at a legal priority.
		next_st.irq_ok = irq_req && irq_src < IRQ_SOURCES
			&& irq_prio != 3'h0 && irq_prio <= PRIO_LEVELS;
	end

	// Operand shaping for the multiplier and divider.
	assign mul_a = mul_req.byte_mode ?
		{{9{mul_req.a_sgn & mul_req.a[7]}}, mul_req.a[7:0]}
		: {mul_req.a_sgn & mul_req.a[15], mul_req.a};
	assign mul_b = mul_req.byte_mode ?
		{{9{mul_req.b_sgn & mul_req.b[7]}}, mul_req.b[7:0]}
		: {mul_req.b_sgn & mul_req.b[15], mul_req.b};
	assign product = mul_a * mul_b;
	assign dvd_full = div_req.wide ? div_req.dividend
		: {{16{div_req.sgn & div_req.dividend[15]}}, div_req.dividend[15:0]};
	assign dvd_neg = div_req.sgn & dvd_full[31];
	assign dsr_neg = div_req.sgn & div_req.divisor[15];
	assign dvd_mag = dvd_neg ? 32'(-dvd_full) : dvd_full;
	assign shifted = {st.div_p[16:0], st.div_a[15]};

	// ----------------------------------------------------------------
	// State register.
	// ----------------------------------------------------------------
	// Clears the array except the stack pointer, which gets its start value.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.file_op_work_reg[SP_IDX] <= SP_RESET;
			st.init <= INIT_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state register, except div_busy, which is decoded from the divider state.
	assign rd_a = st.rd_a;
	assign rd_b = st.rd_b;
	assign eff_addr = st.ea;
	assign addr_trap = st.addr_trap;
	assign dm_rdata = st.dm_rdata;
	assign dm_hit = st.dm_hit;
	assign prog_rd = st.prog_rd;
	assign prog_addr = st.prog_addr;
	assign pc = st.pc;
	assign instr_word = st.instr;
	assign stall = st.stall;
	assign rep_busy = st.rep_busy;
	assign mul_res = st.mul_res;
	assign quotient = st.quot;
	assign remainder = st.rem;
	assign div_busy = st.div_state != CWRC_DIV_IDLE;
	assign div_done = st.div_done;
	assign irq_ok = st.irq_ok;

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	logic quiet;
	assign quiet = !ptr_op.en && !stk_op.push && !stk_op.pop
		&& !stk_op.link && !stk_op.unlink && !dm_req.en;

	sequence s_div_start;
		div_req.start && st.div_state == CWRC_DIV_IDLE;
	endsequence
	sequence s_div_run;
		(!flow.irq_take)[*8] ##1 (!flow.irq_take)[*8] ##1 (!flow.irq_take)[*2];
	endsequence

	sp_align_a: assert property (st.file_op_work_reg[SP_IDX][0] == 1'b0)
		else $error("stack pointer bit 0 set");
	byte_keep_a: assert property (reg_op.wr_en && reg_op.wr_byte && quiet
		|=> st.file_op_work_reg[$past(idx)][15:8] == $past(st.file_op_work_reg[idx][15:8]))
		else $error("byte write changed high byte");
	data_wins_a: assert property (ptr_op.en && dm_req.en && dm_req.we
		&& dm_req.be == 2'b11 && !reg_op.wr_en && ptr_op.mode != CWRC_PM_NONE
		&& cwrc_in_file_op_work_reg_win(dm_req.addr)
		&& cwrc_file_op_work_reg_idx(dm_req.addr) == ptr_op.sel && ptr_op.sel != SP_IDX
		|=> st.file_op_work_reg[$past(ptr_op.sel)] == $past(dm_req.wdata))
		else $error("pointer update beat data write");
	uninit_trap_a: assert property (ptr_op.en && !st.init[ptr_op.sel]
		|=> addr_trap ##1 !addr_trap || $past(ptr_op.en))
		else $error("uninitialized pointer not trapped");
	file_sel_a: assert property (reg_op.wr_en && reg_op.file_op
		&& !reg_op.wr_byte && quiet
		|=> st.file_op_work_reg[WZ_IDX] == $past(reg_op.wr_data) && st.init[WZ_IDX])
		else $error("file op did not write first register");
	map_third_a: assert property (dm_req.en && !dm_req.we
		&& dm_req.addr == 16'h0004 |=> dm_rdata == $past(st.file_op_work_reg[2]) && dm_hit)
		else $error("address 0x0004 not the third register");
	mul_one_a: assert property (mul_req.en && !mul_req.a_sgn
		&& !mul_req.b_sgn && !mul_req.byte_mode
		|=> mul_res == $past(mul_req.a) * $past(mul_req.b))
		else $error("unsigned multiply wrong or late");
	div_len_a: assert property (s_div_start ##1 s_div_run
		|=> div_done && $past(!div_done))
		else $error("divide not done in 19 cycles");
	rep_freeze_a: assert property (rep_busy && flow.irq_take
		&& !flow.rep_load && !dm_req.en |=> $stable(st.loop_count))
		else $error("repeat count moved during interrupt");
	win_map_a: assert property (dm_req.en && dm_req.addr[15]
		&& st.core_ctl[CTL_PSV_BIT] |=> prog_rd
		&& prog_addr == {1'b0, $past(st.win_page), $past(dm_req.addr[14:0])})
		else $error("program window address wrong");
	push_step_a: assert property (stk_op.push && !ptr_op.en && !dm_req.en
		&& !reg_op.wr_en |=> st.file_op_work_reg[SP_IDX] == $past(st.file_op_work_reg[SP_IDX]) + 16'h0002)
		else $error("push did not advance stack pointer");
endmodule : cwrc_core

// >>> common/cwrc_pkg.sv
package cwrc_pkg;
	// ----------------------------------------------------------------
	// Sizes and map of the working register core.
	// ----------------------------------------------------------------
	localparam int NUM_WREGS = 16;
	localparam int WORD_W = 16;
	localparam int PC_W = 24;
	localparam int INSTR_W = 24;
	localparam int PAGE_W = 8;
	localparam int REP_W = 14;
	localparam int PSV_OFS_W = 15;
	localparam int MUL_W = 17;
	localparam logic [3:0] WZ_IDX = 4'h0;
	localparam logic [3:0] FP_IDX = 4'hE;
	localparam logic [3:0] SP_IDX = 4'hF;
	localparam logic [15:0] SP_RESET = 16'h0800;
	localparam logic [15:0] INIT_RESET = 16'h8000;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [23:0] PC_STEP = 24'h000002;
	localparam logic [15:0] FILE_OP_WORK_REG_WIN_END = 16'h0020;
	localparam logic [15:0] ADDR_PC_LO = 16'h002E;
	localparam logic [15:0] ADDR_PC_HI = 16'h0030;
	localparam logic [15:0] ADDR_TBL_PAGE = 16'h0032;
	localparam logic [15:0] ADDR_WIN_PAGE = 16'h0034;
	localparam logic [15:0] ADDR_LOOP_CNT = 16'h0036;
	localparam logic [15:0] ADDR_CORE_CTL = 16'h0044;
	localparam int CTL_PSV_BIT = 2;
	localparam logic [4:0] DIV_LAST_STEP = 5'h0F;
	localparam int TRAP_SOURCES = 8;
	localparam logic [6:0] IRQ_SOURCES = 7'h76;
	localparam logic [2:0] PRIO_LEVELS = 3'h7;

	// ----------------------------------------------------------------
	// Request groups and state.
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CWRC_PM_NONE, CWRC_PM_POST_INC, CWRC_PM_POST_DEC,
		CWRC_PM_PRE_INC, CWRC_PM_PRE_DEC
	} cwrc_ptr_mode_t;
	typedef enum logic [1:0] {
		CWRC_DIV_IDLE, CWRC_DIV_STEP, CWRC_DIV_FIX, CWRC_DIV_SIGN
	} cwrc_div_state_t;
	typedef struct packed {
		logic [3:0] rd_a_sel; logic [3:0] rd_b_sel; logic file_op;
		logic wr_en; logic [3:0] wr_sel; logic wr_byte; logic [15:0] wr_data;
	} cwrc_reg_op_t;
	typedef struct packed {
		logic en; logic [3:0] sel; cwrc_ptr_mode_t mode; logic byte_step;
	} cwrc_ptr_op_t;
	typedef struct packed {
		logic en; logic we; logic [15:0] addr; logic [1:0] be;
		logic [15:0] wdata;
	} cwrc_dm_req_t;
	typedef struct packed {
		logic push; logic pop; logic link; logic unlink;
		logic [14:0] frame_bytes;
	} cwrc_stack_op_t;
	typedef struct packed {
		logic en; logic [15:0] a; logic [15:0] b;
		logic a_sgn; logic b_sgn; logic byte_mode;
	} cwrc_mul_req_t;
	typedef struct packed {
		logic start; logic [31:0] dividend; logic [15:0] divisor;
		logic sgn; logic wide;
	} cwrc_div_req_t;
	typedef struct packed {
		logic fetch_adv; logic [23:0] fetch_word; logic pc_load;
		logic [23:0] pc_target; logic multi; logic rep_load;
		logic [13:0] rep_count; logic irq_take;
	} cwrc_flow_t;
	typedef struct packed {
		logic [NUM_WREGS-1:0][15:0] file_op_work_reg; logic [15:0] init;
		logic [15:0] rd_a; logic [15:0] rd_b; logic [15:0] ea;
		logic addr_trap; logic [15:0] dm_rdata; logic dm_hit;
		logic prog_rd; logic [23:0] prog_addr; logic [23:0] pc;
		logic [23:0] instr; logic stall; logic [7:0] tbl_page;
		logic [7:0] win_page; logic [15:0] core_ctl;
		logic [13:0] loop_count; logic rep_busy; logic [31:0] mul_res;
		cwrc_div_state_t div_state; logic [4:0] div_cnt;
		logic [17:0] div_p; logic [15:0] div_a; logic [15:0] div_d;
		logic div_qneg; logic div_rneg; logic [15:0] quot;
		logic [15:0] rem; logic div_done; logic irq_ok;
	} cwrc_state_t;
endpackage : cwrc_pkg

// >>> sim/cwrc_prog_model.sv
`timescale 1ns/1ns
module cwrc_prog_model
	import cwrc_pkg::*;
(
	// Program address from the core.
	input wire logic [23:0] pc,
	// Instruction word handed back to the fetch stage.
	output logic [23:0] fetch_word
);
	// ----------------------------------------------------------------
	// Program memory content.
	// ----------------------------------------------------------------
	// Each 24-bit location holds a word made from its own address.
	assign fetch_word = pc ^ 24'hA5A5A5;
endmodule : cwrc_prog_model

// >>> sim/cwrc_core_bench.sv
`timescale 1ns/1ns
module cwrc_core_bench
	import cwrc_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals, model and design.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] sel; logic byt; logic [15:0] data; logic [15:0] exp;
	} cwrc_row_t;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	cwrc_reg_op_t reg_op;
	cwrc_ptr_op_t ptr_op;
	cwrc_stack_op_t stk_op;
	cwrc_flow_t fl;
	cwrc_flow_t flow_in;
	cwrc_dm_req_t dm_req;
	cwrc_mul_req_t mul_req;
	cwrc_div_req_t div_req;
	logic irq_req;
	logic [6:0] irq_src;
	logic [2:0] irq_prio;
	logic [15:0] rd_a, rd_b, eff_addr, dm_rdata, quotient, remainder;
	logic addr_trap, dm_hit, prog_rd, stall, rep_busy;
	logic div_busy, div_done, irq_ok;
	logic [23:0] prog_addr, pc, instr_word, fw;
	logic [31:0] mul_res;
	int err_count = 0;
	int tests_run = 0;
	int n;
	cwrc_row_t rows [6];
	logic [6:0] isrc [3] = '{7'h75, 7'h76, 7'h05};
	logic [2:0] ipri [3] = '{3'h7, 3'h7, 3'h0};
	logic iexp [3] = '{1'b1, 1'b0, 1'b0};

	// The fetch word comes from the program memory model.
	always_comb begin
		flow_in = fl;
		flow_in.fetch_word = fw;
	end

	cwrc_prog_model i_prog (.pc(pc), .fetch_word(fw));

	cwrc_core i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_op(reg_op),
		.ptr_op(ptr_op), .stk_op(stk_op), .flow(flow_in), .dm_req(dm_req),
		.mul_req(mul_req), .div_req(div_req), .irq_req(irq_req),
		.irq_src(irq_src), .irq_prio(irq_prio), .rd_a(rd_a), .rd_b(rd_b),
		.eff_addr(eff_addr), .addr_trap(addr_trap), .dm_rdata(dm_rdata),
		.dm_hit(dm_hit), .prog_rd(prog_rd), .prog_addr(prog_addr), .pc(pc),
		.instr_word(instr_word), .stall(stall), .rep_busy(rep_busy),
		.mul_res(mul_res), .quotient(quotient), .remainder(remainder),
		.div_busy(div_busy), .div_done(div_done), .irq_ok(irq_ok));

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	// Returns every request to idle.
	task automatic clr();
		reg_op = '0;
		ptr_op = '0;
		stk_op = '0;
		fl = '0;
		dm_req = '0;
		mul_req = '0;
		div_req = '0;
		irq_req = 1'b0;
		irq_src = 7'h00;
		irq_prio = 3'h0;
	endtask : clr

	// Lets the request edge pass and the registered answers settle.
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask : step

	// Compares a seen value with the expected one.
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Register-direct write of a word or a low byte.
	task automatic wr(input logic [3:0] sel, input logic byt,
		input logic [15:0] d);
		reg_op.wr_en = 1'b1;
		reg_op.wr_sel = sel;
		reg_op.wr_byte = byt;
		reg_op.wr_data = d;
		step();
		clr();
	endtask : wr

	// Reads two registers onto rd_a and rd_b.
	task automatic rd(input logic [3:0] a, input logic [3:0] b);
		reg_op.rd_a_sel = a;
		reg_op.rd_b_sel = b;
		step();
		clr();
	endtask : rd

	// One data memory access; a read when be is zero.
	task automatic dm(input logic [15:0] a, input logic [1:0] be,
		input logic [15:0] d);
		dm_req.en = 1'b1;
		dm_req.we = (be != 2'h0);
		dm_req.addr = a;
		dm_req.be = be;
		dm_req.wdata = d;
		step();
		clr();
	endtask : dm

	// Uses a register as a post-incremented pointer.
	task automatic ptr(input logic [3:0] sel);
		ptr_op.en = 1'b1;
		ptr_op.sel = sel;
		ptr_op.mode = CWRC_PM_POST_INC;
		step();
		clr();
	endtask : ptr

	// Starts 100 / 7; counts cycles to done, start edge included.
	task automatic run_div(input logic irq, output int cnt);
		div_req.start = 1'b1;
		div_req.dividend = 32'h00000064;
		div_req.divisor = 16'h0007;
		step();
		clr();
		chk("div busy", div_busy, 1'b1);
		cnt = 1;
		fl.irq_take = irq;
		while (div_done !== 1'b1 && cnt < 40) begin
			step();
			fl.irq_take = 1'b0;
			cnt++;
		end
	endtask : run_div

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence.
	// ----------------------------------------------------------------
	// Clock of 40 ns period.
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// Cuts a hang short well after the sequence should have ended.
	initial begin
		#200000;
		err_count++;
		finish_test();
	end

	// Main sequence: reset, stack and trap checks, row table, then the awkward cases.
	initial begin
		clr();
		rows[0] = '{4'h1, 1'b0, 16'h1234, 16'h1234};
		rows[1] = '{4'h1, 1'b1, 16'hABCD, 16'h12CD};
		rows[2] = '{4'h2, 1'b0, 16'h0004, 16'h0004};
		rows[3] = '{4'hF, 1'b0, 16'h1235, 16'h1234};
		rows[4] = '{4'hE, 1'b0, 16'hBEEF, 16'hBEEF};
		rows[5] = '{4'h3, 1'b0, 16'h1111, 16'h1111};
		repeat (20) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		rd(4'h0, 4'hF);
		chk("reg0 after reset", rd_a, 16'h0000);
		chk("sp after reset", rd_b, 16'h0800);
		stk_op.link = 1'b1;
		stk_op.frame_bytes = 15'h0004;
		step();
		clr();
		chk("link address", eff_addr, 16'h0800);
		rd(4'hE, 4'hF);
		chk("frame pointer", rd_a, 16'h0802);
		chk("sp after link", rd_b, 16'h0806);
		stk_op.push = 1'b1;
		step();
		clr();
		chk("push address", eff_addr, 16'h0806);
		stk_op.pop = 1'b1;
		step();
		clr();
		rd(4'hF, 4'hE);
		chk("sp after pop", rd_a, 16'h0806);
		stk_op.unlink = 1'b1;
		step();
		clr();
		chk("unlink address", eff_addr, 16'h0800);
		ptr(4'h4);
		chk("trap uninit", addr_trap, 1'b1);
		step();
		chk("trap pulse", addr_trap, 1'b0);
		foreach (rows[i]) begin
			wr(rows[i].sel, rows[i].byt, rows[i].data);
			dm({11'h000, rows[i].sel, 1'b0}, 2'h0, 16'h0000);
			chk("mapped read", dm_rdata, rows[i].exp);
			chk("window hit", dm_hit, 1'b1);
		end
		ptr_op.en = 1'b1;
		ptr_op.sel = 4'h2;
		ptr_op.mode = CWRC_PM_POST_INC;
		dm(16'h0004, 2'h3, 16'h1234);
		rd(4'h2, 4'h0);
		chk("write beats modify", rd_a, 16'h1234);
		dm(16'h0006, 2'h2, 16'hAB00);
		dm(16'h0006, 2'h0, 16'h0000);
		chk("high byte write", dm_rdata, 16'hAB11);
		reg_op.file_op = 1'b1;
		wr(4'h5, 1'b0, 16'h0F0F);
		dm(16'h000A, 2'h0, 16'h0000);
		chk("reg5 untouched", dm_rdata, 16'h0000);
		reg_op.file_op = 1'b1;
		rd(4'h5, 4'h0);
		chk("file operand", rd_a, 16'h0F0F);
		wr(4'h6, 1'b1, 16'h00AA);
		ptr(4'h6);
		chk("byte no init", addr_trap, 1'b1);
		wr(4'h6, 1'b0, 16'h0100);
		ptr(4'h6);
		chk("word init", addr_trap, 1'b0);
		// The remaining pointer modes; pre-increment and post-decrement use a byte step.
		ptr_op = '{1'b1, 4'h6, CWRC_PM_PRE_DEC, 1'b0};
		step();
		chk("pre-decrement", eff_addr, 16'h0100);
		ptr_op.mode = CWRC_PM_PRE_INC;
		ptr_op.byte_step = 1'b1;
		step();
		chk("byte pre-increment", eff_addr, 16'h0101);
		ptr_op.mode = CWRC_PM_POST_DEC;
		step();
		clr();
		chk("post-decrement", eff_addr, 16'h0101);
		rd(4'h6, 4'h0);
		chk("pointer after steps", rd_a, 16'h0100);
		// A second reset in mid-run clears written registers again.
		sys_rst = 1'b1;
		step();
		sys_rst = 1'b0;
		rd(4'h3, 4'hF);
		chk("reg3 after reset", rd_a, 16'h0000);
		chk("sp reset again", rd_b, 16'h0800);
		ptr(4'h3);
		chk("init cleared", addr_trap, 1'b1);
		mul_req = '{1'b1, 16'hFFFD, 16'h0005, 1'b1, 1'b1, 1'b0};
		step();
		clr();
		chk("signed mul", mul_res, 32'hFFFFFFF1);
		mul_req = '{1'b1, 16'h00FD, 16'h0003, 1'b0, 1'b0, 1'b1};
		step();
		clr();
		chk("byte mul", mul_res, 32'h000002F7);
		mul_req = '{1'b1, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 1'b0};
		step();
		clr();
		chk("unsigned mul", mul_res, 32'hFFFE0001);
		run_div(1'b0, n);
		chk("div cycles", n, 32'h00000013);
		chk("quotient", quotient, 16'h000E);
		chk("remainder", remainder, 16'h0002);
		chk("div idle", div_busy, 1'b0);
		run_div(1'b1, n);
		chk("div paused", n, 32'h00000014);
		dm(ADDR_WIN_PAGE, 2'h3, 16'h0003);
		dm(ADDR_CORE_CTL, 2'h3, 16'h0004);
		dm(16'h8006, 2'h0, 16'h0000);
		chk("window read", prog_rd, 1'b1);
		chk("window addr", prog_addr, 24'h018006);
		fl.fetch_adv = 1'b1;
		step();
		clr();
		chk("fetched word", instr_word, 24'hA5A5A5);
		chk("pc step", pc, 24'h000002);
		fl.pc_load = 1'b1;
		fl.pc_target = 24'hFFFFFE;
		step();
		fl = '0;
		fl.fetch_adv = 1'b1;
		step();
		clr();
		chk("pc wraps", pc, 24'h000000);
		fl.multi = 1'b1;
		step();
		clr();
		chk("stall set", stall, 1'b1);
		step();
		chk("stall one cycle", stall, 1'b0);
		fl.rep_load = 1'b1;
		fl.rep_count = 14'h0001;
		step();
		fl = '0;
		fl.fetch_adv = 1'b1;
		fl.irq_take = 1'b1;
		step();
		fl.irq_take = 1'b0;
		step();
		chk("repeat held", rep_busy, 1'b1);
		step();
		clr();
		chk("repeat ends", rep_busy, 1'b0);
		foreach (isrc[i]) begin
			irq_req = 1'b1;
			irq_src = isrc[i];
			irq_prio = ipri[i];
			step();
			clr();
			chk("irq legal", irq_ok, iexp[i]);
		end
		finish_test();
	end
endmodule : cwrc_core_bench
